// file: verilog/ccl_pkg.sv
// Package for the paged current calibration and overvoltage limit bank.
// Assumes a single 10 MHz system clock and a command-coded register port.
package ccl_pkg;
    // ************************************************************
    // Command codes and geometry
    // ************************************************************
    localparam logic [7:0] CCL_CMD_GAIN = 8'h38;
    localparam logic [7:0] CCL_CMD_OFFSET = 8'h39;
    localparam logic [7:0] CCL_CMD_OV_LIMIT = 8'h40;
    localparam int CCL_PAGES = 2;
    localparam int CCL_DW = 16;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [15:0] CCL_GAIN_RST = 16'haa66;
    localparam logic [15:0] CCL_OFFSET_RST = 16'h0000;
    // Limit default is setpoint * 115 / 100
    localparam logic [7:0] CCL_OV_SCALE_NUM = 8'h73;
    localparam logic [7:0] CCL_OV_SCALE_DEN = 8'h64;

    // ************************************************************
    // Linear-11 fields
    // ************************************************************
    localparam int CCL_EXP_MSB = 15;
    localparam int CCL_EXP_LSB = 11;
    localparam int CCL_MANT_MSB = 10;
    localparam int CCL_FRAC_BITS = 8;

    // ************************************************************
    // Current arithmetic
    // ************************************************************
    localparam int CCL_DIV_W = 32;
    localparam logic [9:0] CCL_MILLI = 10'h3e8;
endpackage : ccl_pkg

// file: verilog/ccl_divider.sv
// Unsigned restoring divider, one quotient bit per clock.
// Assumes the caller holds off start while busy is high.
`timescale 1ns/10ps
module ccl_divider
    import ccl_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Request
    input wire logic start,
    input wire logic [CCL_DIV_W-1:0] dividend,
    input wire logic [CCL_DIV_W-1:0] divisor,
    // Result
    output logic busy,
    output logic done,
    output logic [CCL_DIV_W-1:0] quotient
);
    logic [CCL_DIV_W-1:0] quo_r, quo_nxt;
    logic [CCL_DIV_W-1:0] rem_r, rem_nxt;
    logic [CCL_DIV_W-1:0] den_r, den_nxt;
    logic [5:0] cnt_r, cnt_nxt;
    logic busy_r, busy_nxt;
    logic done_r, done_nxt;
    logic [CCL_DIV_W:0] trial;

    always_comb begin
        quo_nxt = quo_r;
        rem_nxt = rem_r;
        den_nxt = den_r;
        cnt_nxt = cnt_r;
        busy_nxt = busy_r;
        done_nxt = 1'b0;
        trial = {rem_r, quo_r[CCL_DIV_W-1]} - {1'b0, den_r};
        if (!busy_r && start) begin
            quo_nxt = dividend;
            rem_nxt = '0;
            den_nxt = divisor;
            cnt_nxt = 6'h20;
            busy_nxt = 1'b1;
        end else if (busy_r) begin
            if (!trial[CCL_DIV_W]) begin
                rem_nxt = trial[CCL_DIV_W-1:0];
                quo_nxt = {quo_r[CCL_DIV_W-2:0], 1'b1};
            end else begin
                rem_nxt = {rem_r[CCL_DIV_W-2:0], quo_r[CCL_DIV_W-1]};
                quo_nxt = {quo_r[CCL_DIV_W-2:0], 1'b0};
            end
            cnt_nxt = cnt_r - 6'h01;
            if (cnt_r == 6'h01) begin
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            quo_r <= '0;
            rem_r <= '0;
            den_r <= '0;
            cnt_r <= '0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            quo_r <= quo_nxt;
            rem_r <= rem_nxt;
            den_r <= den_nxt;
            cnt_r <= cnt_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
        end
    end

    assign busy = busy_r;
    assign done = done_r;
    assign quotient = quo_r;
endmodule : ccl_divider

// file: verilog/ccl_regs.sv
// Paged current calibration and overvoltage limit registers.
// Assumes the bus controller decodes transactions into one-cycle command
// strobes, and that measurements arrive synchronous to sys_clk.
`timescale 1ns/10ps
module ccl_regs
    import ccl_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Command port
    input wire logic [0:0] page_sel,
    input wire logic [7:0] cmd_code,
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    input wire logic [15:0] cmd_wdata,
    input wire logic write_protect,
    output logic [15:0] cmd_rdata,
    output logic cmd_rvalid,
    output logic cmd_refused,
    output logic cmd_unsupported,
    // Strap and fault control
    input wire logic [15:0] output_voltage_setpoint,
    input wire logic clear_faults,
    // Measurements, per page
    input wire logic [CCL_PAGES*16-1:0] vout_meas,
    input wire logic [CCL_PAGES*16-1:0] sense_uv,
    // Results and fault signalling
    output logic [CCL_PAGES*32-1:0] iout_ma,
    output logic [CCL_PAGES-1:0] ov_fault,
    output logic [CCL_PAGES-1:0] output_disable,
    output logic alert_line_n
);
    // ************************************************************
    // Helpers
    // ************************************************************
    // Linear-11 to signed fixed point with 8 fraction bits
    function automatic logic signed [31:0] lin11_to_fix(
        input logic [15:0] raw
    );
        logic signed [4:0] n;
        logic signed [31:0] y;
        logic signed [6:0] sh;
        n = $signed(raw[CCL_EXP_MSB:CCL_EXP_LSB]);
        y = 32'($signed(raw[CCL_MANT_MSB:0]));
        sh = 7'(n) + 7'(CCL_FRAC_BITS);
        if (sh >= 0) begin
            lin11_to_fix = y <<< sh[4:0];
        end else begin
            lin11_to_fix = y >>> 5'(-sh);
        end
    endfunction : lin11_to_fix

    function automatic logic [15:0] page_word(
        input logic [CCL_PAGES*16-1:0] bus,
        input int p
    );
        page_word = bus[p*16 +: 16];
    endfunction : page_word

    // ************************************************************
    // Register state
    // ************************************************************
    logic [15:0] gain_r [CCL_PAGES];
    logic [15:0] gain_nxt [CCL_PAGES];
    logic [15:0] offset_r [CCL_PAGES];
    logic [15:0] offset_nxt [CCL_PAGES];
    logic [15:0] ovlim_r [CCL_PAGES];
    logic [15:0] ovlim_nxt [CCL_PAGES];
    logic strap_done_r, strap_done_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic rvalid_r, rvalid_nxt;
    logic refused_r, refused_nxt;
    logic unsup_r, unsup_nxt;
    logic known_cmd;
    logic [23:0] ov_prod;
    logic [23:0] ov_default;

    assign known_cmd = (cmd_code == CCL_CMD_GAIN) ||
        (cmd_code == CCL_CMD_OFFSET) || (cmd_code == CCL_CMD_OV_LIMIT);
    assign ov_prod = 24'(output_voltage_setpoint) * 24'(CCL_OV_SCALE_NUM);
    assign ov_default = ov_prod / 24'(CCL_OV_SCALE_DEN);

    always_comb begin
        for (int p = 0; p < CCL_PAGES; p++) begin
            gain_nxt[p] = gain_r[p];
            offset_nxt[p] = offset_r[p];
            ovlim_nxt[p] = ovlim_r[p];
        end
        strap_done_nxt = 1'b1;
        rdata_nxt = rdata_r;
        rvalid_nxt = 1'b0;
        refused_nxt = 1'b0;
        unsup_nxt = 1'b0;
        // Strap captured on the first edge after reset release
        if (!strap_done_r) begin
            for (int p = 0; p < CCL_PAGES; p++) begin
                if (ov_default > 24'h00ffff) begin
                    ovlim_nxt[p] = 16'hffff;
                end else begin
                    ovlim_nxt[p] = ov_default[15:0];
                end
            end
        end
        if (cmd_wr) begin
            if (!known_cmd) begin
                unsup_nxt = 1'b1;
            end else if (write_protect) begin
                refused_nxt = 1'b1;
            end else begin
                case (cmd_code)
                    CCL_CMD_GAIN: gain_nxt[page_sel] = cmd_wdata;
                    CCL_CMD_OFFSET: offset_nxt[page_sel] = cmd_wdata;
                    CCL_CMD_OV_LIMIT: ovlim_nxt[page_sel] = cmd_wdata;
                    default: unsup_nxt = 1'b1;
                endcase
            end
        end else if (cmd_rd) begin
            rvalid_nxt = 1'b1;
            case (cmd_code)
                CCL_CMD_GAIN: rdata_nxt = gain_r[page_sel];
                CCL_CMD_OFFSET: rdata_nxt = offset_r[page_sel];
                CCL_CMD_OV_LIMIT: rdata_nxt = ovlim_r[page_sel];
                default: begin
                    rdata_nxt = 16'h0000;
                    unsup_nxt = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            for (int p = 0; p < CCL_PAGES; p++) begin
                gain_r[p] <= CCL_GAIN_RST;
                offset_r[p] <= CCL_OFFSET_RST;
                ovlim_r[p] <= 16'h0000;
            end
            strap_done_r <= 1'b0;
            rdata_r <= 16'h0000;
            rvalid_r <= 1'b0;
            refused_r <= 1'b0;
            unsup_r <= 1'b0;
        end else begin
            for (int p = 0; p < CCL_PAGES; p++) begin
                gain_r[p] <= gain_nxt[p];
                offset_r[p] <= offset_nxt[p];
                ovlim_r[p] <= ovlim_nxt[p];
            end
            strap_done_r <= strap_done_nxt;
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            refused_r <= refused_nxt;
            unsup_r <= unsup_nxt;
        end
    end

    assign cmd_rdata = rdata_r;
    assign cmd_rvalid = rvalid_r;
    assign cmd_refused = refused_r;
    assign cmd_unsupported = unsup_r;

    // ************************************************************
    // Overvoltage monitor
    // ************************************************************
    logic [CCL_PAGES-1:0] fault_r, fault_nxt;

    always_comb begin
        for (int p = 0; p < CCL_PAGES; p++) begin
            fault_nxt[p] = fault_r[p];
            if (clear_faults) begin
                fault_nxt[p] = 1'b0;
            end
            // Trip wins over a clear in the same cycle
            if (strap_done_r && page_word(vout_meas, p) > ovlim_r[p]) begin
                fault_nxt[p] = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            fault_r <= '0;
        end else begin
            fault_r <= fault_nxt;
        end
    end

    assign ov_fault = fault_r;
    assign output_disable = fault_r;
    assign alert_line_n = ~|fault_r;

    // ************************************************************
    // Output current, pages served in turn
    // ************************************************************
    typedef enum logic [1:0] {
        CCL_IDLE,
        CCL_WAIT,
        CCL_STORE
    } ccl_calc_e;

    ccl_calc_e calc_r, calc_nxt;
    logic [0:0] cpage_r, cpage_nxt;
    logic [31:0] iout_r [CCL_PAGES];
    logic [31:0] iout_nxt [CCL_PAGES];
    logic div_start;
    logic div_busy;
    logic div_done;
    logic [31:0] div_quo;
    logic signed [31:0] gain_fix;
    logic signed [31:0] off_fix;
    logic signed [41:0] off_ma_wide;
    logic [31:0] div_num;
    logic [31:0] div_den;

    assign gain_fix = lin11_to_fix(gain_r[cpage_r]);
    assign off_fix = lin11_to_fix(offset_r[cpage_r]);
    assign off_ma_wide = (42'(off_fix) * 42'($signed({1'b0, CCL_MILLI}))) >>>
        CCL_FRAC_BITS;
    // Microvolts over milliohms gives milliamps
    assign div_num = {8'h00, page_word(sense_uv, int'(cpage_r)), 8'h00};
    assign div_den = (gain_fix > 0) ? 32'(gain_fix) : 32'h00000000;

    always_comb begin
        calc_nxt = calc_r;
        cpage_nxt = cpage_r;
        div_start = 1'b0;
        for (int p = 0; p < CCL_PAGES; p++) begin
            iout_nxt[p] = iout_r[p];
        end
        case (calc_r)
            CCL_IDLE: begin
                if (!div_busy) begin
                    div_start = 1'b1;
                    calc_nxt = CCL_WAIT;
                end
            end
            CCL_WAIT: begin
                if (div_done) begin
                    calc_nxt = CCL_STORE;
                end
            end
            CCL_STORE: begin
                // Zero or negative gain saturates the reading
                if (div_den == 32'h00000000) begin
                    iout_nxt[cpage_r] = 32'h7fffffff;
                end else begin
                    iout_nxt[cpage_r] = div_quo + off_ma_wide[31:0];
                end
                cpage_nxt = cpage_r + 1'b1;
                calc_nxt = CCL_IDLE;
            end
            default: calc_nxt = CCL_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            calc_r <= CCL_IDLE;
            cpage_r <= 1'b0;
            for (int p = 0; p < CCL_PAGES; p++) begin
                iout_r[p] <= 32'h00000000;
            end
        end else begin
            calc_r <= calc_nxt;
            cpage_r <= cpage_nxt;
            for (int p = 0; p < CCL_PAGES; p++) begin
                iout_r[p] <= iout_nxt[p];
            end
        end
    end

    always_comb begin
        for (int p = 0; p < CCL_PAGES; p++) begin
            iout_ma[p*32 +: 32] = iout_r[p];
        end
    end

    ccl_divider u_div (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .start(div_start),
        .dividend(div_num),
        .divisor(div_den),
        .busy(div_busy),
        .done(div_done),
        .quotient(div_quo)
    );
endmodule : ccl_regs

// file: test/ccl_regs_props.sv
// Checker for the paged calibration and limit bank.
// Assumes it is bound onto ccl_regs and sees only its ports.
`timescale 1ns/10ps
module ccl_regs_props
    import ccl_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Command port
    input wire logic [0:0] page_sel,
    input wire logic [7:0] cmd_code,
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    input wire logic [15:0] cmd_wdata,
    input wire logic write_protect,
    input wire logic [15:0] cmd_rdata,
    input wire logic cmd_rvalid,
    input wire logic cmd_refused,
    input wire logic cmd_unsupported,
    // Fault status
    input wire logic clear_faults,
    input wire logic [CCL_PAGES-1:0] ov_fault,
    input wire logic [CCL_PAGES-1:0] output_disable,
    input wire logic alert_line_n
);
    // ********************************************************
    // Properties
    // ********************************************************
    logic known;
    assign known = cmd_code == CCL_CMD_GAIN || cmd_code == CCL_CMD_OFFSET
        || cmd_code == CCL_CMD_OV_LIMIT;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    property p_rd_ans;
        cmd_rd && !cmd_wr && known |=> cmd_rvalid && !cmd_unsupported;
    endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read unanswered");
    property p_refuse;
        cmd_wr && write_protect && known |=> cmd_refused && !cmd_rvalid;
    endproperty
    a_refuse: assert property (p_refuse) else $error("write not refused");
    property p_accept;
        cmd_wr && !write_protect |=> !cmd_refused;
    endproperty
    a_accept: assert property (p_accept) else $error("write refused");
    property p_unsup;
        cmd_rd && !cmd_wr && !known |=> cmd_unsupported && cmd_rdata == 16'h0;
    endproperty
    a_unsup: assert property (p_unsup) else $error("unknown code read");
    property p_gain_store;
        $past(cmd_wr && !write_protect && cmd_code == CCL_CMD_GAIN)
            && cmd_rd && !cmd_wr && cmd_code == CCL_CMD_GAIN
            && page_sel == $past(page_sel)
            |=> cmd_rdata == $past(cmd_wdata, 2);
    endproperty
    a_gain_store: assert property (p_gain_store) else $error("gain lost");
    property p_sticky;
        ov_fault != '0 && !clear_faults
            |=> (ov_fault & $past(ov_fault)) == $past(ov_fault);
    endproperty
    a_sticky: assert property (p_sticky) else $error("fault dropped");
    property p_alert;
        alert_line_n == (ov_fault == '0);
    endproperty
    a_alert: assert property (p_alert) else $error("alert mismatch");
    property p_disable;
        output_disable == ov_fault;
    endproperty
    a_disable: assert property (p_disable) else $error("no shutdown");
endmodule : ccl_regs_props
bind ccl_regs ccl_regs_props ccl_regs_props_inst (.sys_clk(sys_clk),
    .nrst(nrst), .page_sel(page_sel), .cmd_code(cmd_code), .cmd_wr(cmd_wr),
    .cmd_rd(cmd_rd), .cmd_wdata(cmd_wdata), .write_protect(write_protect),
    .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid),
    .cmd_refused(cmd_refused), .cmd_unsupported(cmd_unsupported),
    .clear_faults(clear_faults), .ov_fault(ov_fault),
    .output_disable(output_disable), .alert_line_n(alert_line_n));

// file: test/ccl_host_model.sv
// Host controller model for the bank's command port.
// Assumes access is called at a falling edge of sys_clk.
`timescale 1ns/10ps
module ccl_host_model (
    // Clock
    input wire logic sys_clk,
    // Command port
    output logic [0:0] page_sel,
    output logic [7:0] cmd_code,
    output logic cmd_wr,
    output logic cmd_rd,
    output logic [15:0] cmd_wdata,
    output logic write_protect,
    input wire logic [15:0] cmd_rdata,
    input wire logic cmd_rvalid,
    input wire logic cmd_refused,
    input wire logic cmd_unsupported
);
    // ********************************************************
    // Command driver
    // ********************************************************
    logic [15:0] got_data;
    logic [2:0] got_flags;
    initial begin
        {page_sel, cmd_code, cmd_wr, cmd_rd, write_protect} = '0;
        cmd_wdata = 16'h0;
    end
    task automatic access(input logic w, input logic r, input logic [0:0] pg,
        input logic [7:0] code, input logic [15:0] d, input logic last);
        page_sel = pg;
        cmd_code = code;
        cmd_wr = w;
        cmd_rd = r;
        cmd_wdata = d;
        @(negedge sys_clk);
        got_data = cmd_rdata;
        got_flags = {cmd_rvalid, cmd_refused, cmd_unsupported};
        if (last) begin
            // Strobes go low; code and data lines are driven to their inverse
            cmd_wr = 1'b0;
            cmd_rd = 1'b0;
            cmd_wdata = ~d;
            cmd_code = ~code;
            // Idle edge so the next call never re-drives in this step
            @(negedge sys_clk);
        end
    endtask : access
    task automatic set_protect(input logic v);
        write_protect = v;
    endtask : set_protect
endmodule : ccl_host_model

// file: test/ccl_regs_tb.sv
// Self-checking bench for the paged calibration and limit bank.
// Assumes ccl_regs, its checker and the host model are compiled first.
`timescale 1ns/10ps
module ccl_regs_tb;
    import ccl_pkg::*;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic [0:0] page_sel;
    logic [7:0] cmd_code;
    logic cmd_wr, cmd_rd, write_protect, cmd_rvalid, cmd_refused;
    logic cmd_unsupported, alert_line_n;
    logic [15:0] cmd_wdata, cmd_rdata;
    logic [15:0] setpoint = 16'h2000;
    logic clear_faults = 1'b0;
    logic [31:0] vout_meas = 32'h0, sense_uv = 32'h0;
    logic [63:0] iout_ma;
    logic [1:0] ov_fault, output_disable;
    logic [15:0] ov_def;
    int errors = 0, tests_run = 0, cycles = 0;
    always #50 sys_clk = ~sys_clk;
    ccl_regs ccl_regs_inst (.sys_clk(sys_clk), .nrst(nrst),
        .page_sel(page_sel), .cmd_code(cmd_code), .cmd_wr(cmd_wr),
        .cmd_rd(cmd_rd), .cmd_wdata(cmd_wdata), .write_protect(write_protect),
        .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid),
        .cmd_refused(cmd_refused), .cmd_unsupported(cmd_unsupported),
        .output_voltage_setpoint(setpoint), .clear_faults(clear_faults),
        .vout_meas(vout_meas), .sense_uv(sense_uv), .iout_ma(iout_ma),
        .ov_fault(ov_fault), .output_disable(output_disable),
        .alert_line_n(alert_line_n));
    ccl_host_model ccl_host_model_inst (.sys_clk(sys_clk),
        .page_sel(page_sel), .cmd_code(cmd_code), .cmd_wr(cmd_wr),
        .cmd_rd(cmd_rd), .cmd_wdata(cmd_wdata), .write_protect(write_protect),
        .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid),
        .cmd_refused(cmd_refused), .cmd_unsupported(cmd_unsupported));
    // ********************************************************
    // Checking and access tasks
    // ********************************************************
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: data %h expected %h", $time, got, exp);
        end
    endtask : chk16
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: status %h expected %h", $time, got, exp);
        end
    endtask : chk32
    task automatic wr(input logic [0:0] pg, input logic [7:0] code,
        input logic [15:0] d, input logic prot);
        ccl_host_model_inst.access(1'b1, 1'b0, pg, code, d, 1'b1);
        chk32({29'h0, ccl_host_model_inst.got_flags}, {30'h0, prot, 1'b0});
    endtask : wr
    task automatic rd(input logic [0:0] pg, input logic [7:0] code,
        input logic [15:0] exp);
        ccl_host_model_inst.access(1'b0, 1'b1, pg, code, 16'h0, 1'b1);
        chk16(ccl_host_model_inst.got_data, exp);
        chk32({29'h0, ccl_host_model_inst.got_flags}, 32'h4);
    endtask : rd
    task automatic chk_fault(input logic [1:0] f);
        repeat (2) @(negedge sys_clk);
        chk32({27'h0, alert_line_n, output_disable, ov_fault},
            {27'h0, f == 2'b00, f, f});
    endtask : chk_fault
    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : final_report
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            final_report();
        end
    end
    // ********************************************************
    // Scenarios
    // ********************************************************
    initial begin
        ov_def = 16'((32'(setpoint) * 32'd115) / 32'd100);
        repeat (5) @(negedge sys_clk);
        nrst = 1'b1;
        repeat (2) @(negedge sys_clk);
        for (int p = 0; p < 2; p++) begin
            rd(1'(p), CCL_CMD_GAIN, 16'haa66);
            rd(1'(p), CCL_CMD_OFFSET, 16'h0000);
            rd(1'(p), CCL_CMD_OV_LIMIT, ov_def);
        end
        wr(1'b0, CCL_CMD_OFFSET, 16'h0002, 1'b0);
        rd(1'b1, CCL_CMD_OFFSET, 16'h0000);
        rd(1'b0, CCL_CMD_OFFSET, 16'h0002);
        ccl_host_model_inst.access(1'b1, 1'b0, 1'b1, CCL_CMD_GAIN, 16'h0001,
            1'b0);
        ccl_host_model_inst.access(1'b0, 1'b1, 1'b1, CCL_CMD_GAIN, 16'h0,
            1'b1);
        chk16(ccl_host_model_inst.got_data, 16'h0001);
        rd(1'b0, CCL_CMD_GAIN, 16'haa66);
        ccl_host_model_inst.set_protect(1'b1);
        wr(1'b0, CCL_CMD_OV_LIMIT, 16'h1234, 1'b1);
        wr(1'b1, CCL_CMD_GAIN, 16'h5555, 1'b1);
        rd(1'b0, CCL_CMD_OV_LIMIT, ov_def);
        rd(1'b1, CCL_CMD_GAIN, 16'h0001);
        ccl_host_model_inst.set_protect(1'b0);
        ccl_host_model_inst.access(1'b0, 1'b1, 1'b0, 8'h41, 16'h0, 1'b1);
        chk16(ccl_host_model_inst.got_data, 16'h0000);
        chk32({29'h0, ccl_host_model_inst.got_flags}, 32'h5);
        ccl_host_model_inst.access(1'b1, 1'b0, 1'b0, 8'h41, 16'h1111, 1'b1);
        chk32({29'h0, ccl_host_model_inst.got_flags}, 32'h1);
        sense_uv = {16'h1388, 16'h0000};
        for (int i = 0; i < 300; i++)
            if (iout_ma !== {32'h1388, 32'h7d0})
                @(negedge sys_clk);
        chk32(iout_ma[31:0], 32'h7d0);
        chk32(iout_ma[63:32], 32'h1388);
        wr(1'b1, CCL_CMD_OV_LIMIT, 16'h4000, 1'b0);
        wr(1'b0, CCL_CMD_OV_LIMIT, 16'hffff, 1'b0);
        vout_meas = {16'h4000, 16'hffff};
        chk_fault(2'b00);
        vout_meas = {16'h4001, 16'hffff};
        chk_fault(2'b10);
        clear_faults = 1'b1;
        @(negedge sys_clk);
        clear_faults = 1'b0;
        chk_fault(2'b10);
        vout_meas = 32'h0;
        @(negedge sys_clk);
        clear_faults = 1'b1;
        @(negedge sys_clk);
        clear_faults = 1'b0;
        chk_fault(2'b00);
        wr(1'b1, CCL_CMD_GAIN, 16'h0000, 1'b0);
        for (int i = 0; i < 300; i++)
            if (iout_ma[63:32] !== 32'h7fffffff)
                @(negedge sys_clk);
        chk32(iout_ma[63:32], 32'h7fffffff);
        // Reset in mid-run brings back the defaults
        nrst = 1'b0;
        repeat (2) @(negedge sys_clk);
        nrst = 1'b1;
        repeat (2) @(negedge sys_clk);
        rd(1'b1, CCL_CMD_GAIN, 16'haa66);
        rd(1'b1, CCL_CMD_OV_LIMIT, ov_def);
        rd(1'b0, CCL_CMD_OFFSET, 16'h0000);
        final_report();
    end
endmodule : ccl_regs_tb
